//--- rtl/csc_pkg.sv
// package: register map, field positions, reset values and encodings of the clock source control
package csc_pkg;
   localparam int CSC_AW = 4;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [CSC_AW-1:0] CSC_OFS_CTRL1 = 4'h0;
   localparam logic [CSC_AW-1:0] CSC_OFS_CTRL2 = 4'h4;
   localparam logic [CSC_AW-1:0] CSC_OFS_TRIM = 4'h8;
   localparam logic [CSC_AW-1:0] CSC_OFS_STAT = 4'hC;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CSC_RST_CTRL1 = 8'h04;
   localparam logic [7:0] CSC_RST_CTRL2 = 8'h40;
   localparam logic [7:0] CSC_RST_TRIM = 8'h80;
   localparam logic CSC_RST_FINE = 1'b0;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CSC_SRC_HI = 7;
   localparam int CSC_SRC_LO = 6;
   localparam int CSC_REFDIV_HI = 5;
   localparam int CSC_REFDIV_LO = 3;
   localparam int CSC_IREF_BIT = 2;
   localparam int CSC_IOUT_BIT = 1;
   localparam int CSC_ISTOP_BIT = 0;
   localparam int CSC_BUSDIV_HI = 7;
   localparam int CSC_BUSDIV_LO = 6;
   localparam int CSC_RANGE_BIT = 5;
   localparam int CSC_GAIN_BIT = 4;
   localparam int CSC_LP_BIT = 3;
   localparam int CSC_EOSC_BIT = 2;
   localparam int CSC_EOUT_BIT = 1;
   localparam int CSC_ESTOP_BIT = 0;
   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CSC_SRC_LOOP = 2'b00,
      CSC_SRC_INT = 2'b01,
      CSC_SRC_EXT = 2'b10,
      CSC_SRC_RSVD = 2'b11
   } csc_src_t;
   typedef enum logic [2:0] {
      CSC_MODE_ENG_INT = 3'b000,
      CSC_MODE_ENG_EXT = 3'b001,
      CSC_MODE_BYP_INT = 3'b010,
      CSC_MODE_BYP_INT_LP = 3'b011,
      CSC_MODE_BYP_EXT = 3'b100,
      CSC_MODE_BYP_EXT_LP = 3'b101
   } csc_mode_t;
endpackage

//--- rtl/csc_wb_slave.sv
// file: classic wishbone slave front end, one-cycle ack per access
`timescale 1ns/1ps
module csc_wb_slave #(
   parameter int AW = 4
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_cyc,
   input wire logic i_stb,
   input wire logic i_we,
   input wire logic [AW-1:0] i_adr,
   input wire logic i_sel0,
   input wire logic [7:0] i_rdata,
   output logic o_wr,
   output logic [AW-1:0] o_wadr,
   output logic o_ack,
   output logic [7:0] o_dat
);
   typedef struct packed {
      logic ack;
      logic [7:0] dat;
   } csc_wb_st_t;
   csc_wb_st_t s_q;
   csc_wb_st_t s_d;
   logic req;
   // ----------------------------------------------------------------
   // request decode
   // ----------------------------------------------------------------
   assign req = i_cyc && i_stb && !s_q.ack;
   assign o_wr = req && i_we && i_sel0;
   assign o_wadr = i_adr;
   assign o_ack = s_q.ack;
   assign o_dat = s_q.dat;
   always_comb begin
      s_d = s_q;
      s_d.ack = req;
      if (req && !i_we) begin
         s_d.dat = i_rdata;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

//--- rtl/csc_mode_track.sv
// file: tracks the clock unit operating mode from the control fields
`timescale 1ns/1ps
module csc_mode_track (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire csc_pkg::csc_src_t i_src,
   input wire logic i_iref,
   input wire logic i_lp,
   input wire logic i_debug,
   output csc_pkg::csc_mode_t o_mode
);
   import csc_pkg::*;
   typedef struct packed {
      csc_mode_t mode;
   } csc_mt_st_t;
   csc_mt_st_t s_q;
   csc_mt_st_t s_d;
   logic lowp;
   assign lowp = i_lp && !i_debug;
   assign o_mode = s_q.mode;
   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      unique case (i_src)
         CSC_SRC_INT: begin
            s_d.mode = lowp ? CSC_MODE_BYP_INT_LP : CSC_MODE_BYP_INT;
         end
         CSC_SRC_EXT: begin
            s_d.mode = lowp ? CSC_MODE_BYP_EXT_LP : CSC_MODE_BYP_EXT;
         end
         default: begin
            s_d.mode = i_iref ? CSC_MODE_ENG_INT : CSC_MODE_ENG_EXT;
         end
      endcase
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s_q.mode <= CSC_MODE_ENG_INT;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

//--- rtl/csc_regs.sv
// file: clock source control registers and the control outputs they steer
//
// Notes on behaviour
// - bits 7:6 of control one pick loop, internal or external bus source
// - bits 5:3 divide loop reference by two to the field value
// - bit 2 of control one: 1 internal, 0 external loop reference
// - bit 1 of control one gates the internal reference clock output
// - bit 0 keeps internal reference running in stop when enabled or used
// - bits 7:6 of control two divide bus source by 1, 2, 4, 8
// - bit 5 of control two drives oscillator range, 1 is high
// - bit 4 of control two drives oscillator gain, 1 is high gain
// - bit 3 disables loop in bypassed modes unless debug active
// - bit 2 of control two: 1 crystal oscillator, 0 external clock
// - bit 1 of control two gates the external reference clock output
// - bit 0 keeps external reference running in stop when enabled or used
// - eight trim bits set internal reference period, larger is longer
// - one extra fine adjust bit sits in the status control register
// - bus clock runs at half the divided unit output
// - source encoding 01 is internal, 10 is external reference
// - bus divider change acts on output at once; here o_bus_div_ratio follows the stored field one cycle later
//
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module csc_regs (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [csc_pkg::CSC_AW-1:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic i_stop,
   input wire logic i_debug_mode,
   output logic o_wb_ack,
   output logic [31:0] o_wb_dat,
   output logic [1:0] o_bus_source_select,
   output logic [7:0] o_ref_div_ratio,
   output logic o_loop_ref_internal_select,
   output logic [3:0] o_bus_div_ratio,
   output logic [4:0] o_sys_div_ratio,
   output logic o_osc_range_high,
   output logic o_osc_high_gain,
   output logic o_osc_enable,
   output logic o_ext_ref_osc_request,
   output logic o_loop_enable,
   output logic o_int_ref_run,
   output logic o_int_ref_clock_gate,
   output logic o_ext_ref_run,
   output logic o_ext_ref_clock_gate,
   output logic [7:0] o_ref_trim,
   output logic o_fine_adjust_bit,
   output csc_pkg::csc_mode_t o_mode
);
   import csc_pkg::*;
   typedef struct packed {
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [7:0] trim;
      logic fine;
      logic [1:0] src;
      logic [7:0] ref_ratio;
      logic iref;
      logic [3:0] bus_ratio;
      logic [4:0] sdiv;
      logic range_hi;
      logic high_gain;
      logic osc_en;
      logic eosc;
      logic loop_en;
      logic irun;
      logic igate;
      logic erun;
      logic egate;
      logic [7:0] trim_o;
      logic fine_o;
   } csc_st_t;
   csc_st_t s_q;
   csc_st_t s_d;
   logic bus_wr;
   logic [CSC_AW-1:0] bus_wadr;
   logic [7:0] bus_rdat;
   logic [7:0] rd_mux;
   csc_mode_t mode;
   csc_mode_t mode_before_stop;
   logic stop_q;
   logic [1:0] wsrc;
   logic bypassed;
   logic int_used;
   logic ext_used;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] csc_pow2(input logic [2:0] sel);
      csc_pow2 = 8'h01 << sel;
   endfunction

   function automatic logic [1:0] csc_fix_src(input logic [1:0] v);
      csc_fix_src = (v == CSC_SRC_RSVD) ? CSC_SRC_LOOP : v;
   endfunction

   // ----------------------------------------------------------------
   // bus front end and mode tracking
   // ----------------------------------------------------------------
   csc_wb_slave #(.AW(CSC_AW)) u_wb (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_cyc(i_wb_cyc),
      .i_stb(i_wb_stb),
      .i_we(i_wb_we),
      .i_adr(i_wb_adr),
      .i_sel0(i_wb_sel[0]),
      .i_rdata(rd_mux),
      .o_wr(bus_wr),
      .o_wadr(bus_wadr),
      .o_ack(o_wb_ack),
      .o_dat(bus_rdat)
   );
   assign o_wb_dat = {24'h000000, bus_rdat};

   csc_mode_track u_mode (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_src(csc_src_t'(s_q.ctrl1[CSC_SRC_HI:CSC_SRC_LO])),
      .i_iref(s_q.ctrl1[CSC_IREF_BIT]),
      .i_lp(s_q.ctrl2[CSC_LP_BIT]),
      .i_debug(i_debug_mode),
      .o_mode(mode)
   );
   assign o_mode = mode;

   // ----------------------------------------------------------------
   // read mux, unmapped offsets read zero
   // ----------------------------------------------------------------
   always_comb begin
      unique case (i_wb_adr)
         CSC_OFS_CTRL1: rd_mux = s_q.ctrl1;
         CSC_OFS_CTRL2: rd_mux = s_q.ctrl2;
         CSC_OFS_TRIM: rd_mux = s_q.trim;
         CSC_OFS_STAT: rd_mux = {mode, 4'h0, s_q.fine};
         default: rd_mux = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // stop-mode memory of the mode in force before stop
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         stop_q <= 1'b0;
         mode_before_stop <= CSC_MODE_ENG_INT;
      end else begin
         stop_q <= i_stop;
         if (!i_stop) begin
            mode_before_stop <= mode;
         end
      end
   end

   assign wsrc = csc_fix_src(i_wb_dat[CSC_SRC_HI:CSC_SRC_LO]);
   assign bypassed = (mode != CSC_MODE_ENG_INT) && (mode != CSC_MODE_ENG_EXT);
   assign int_used = (mode_before_stop == CSC_MODE_ENG_INT) ||
                     (mode_before_stop == CSC_MODE_BYP_INT) ||
                     (mode_before_stop == CSC_MODE_BYP_INT_LP);
   assign ext_used = (mode_before_stop == CSC_MODE_ENG_EXT) ||
                     (mode_before_stop == CSC_MODE_BYP_EXT) ||
                     (mode_before_stop == CSC_MODE_BYP_EXT_LP);

   // ----------------------------------------------------------------
   // register writes and derived controls
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      if (bus_wr) begin
         unique case (bus_wadr)
            CSC_OFS_CTRL1: s_d.ctrl1 = {wsrc, i_wb_dat[5:0]};
            CSC_OFS_CTRL2: s_d.ctrl2 = i_wb_dat[7:0];
            CSC_OFS_TRIM: s_d.trim = i_wb_dat[7:0];
            CSC_OFS_STAT: s_d.fine = i_wb_dat[0];
            default: s_d.ctrl1 = s_q.ctrl1;
         endcase
      end
      // controls follow the stored fields one cycle later
      s_d.src = csc_fix_src(s_q.ctrl1[CSC_SRC_HI:CSC_SRC_LO]);
      s_d.ref_ratio = csc_pow2(s_q.ctrl1[CSC_REFDIV_HI:CSC_REFDIV_LO]);
      s_d.iref = s_q.ctrl1[CSC_IREF_BIT];
      s_d.bus_ratio = 4'(csc_pow2({1'b0, s_q.ctrl2[CSC_BUSDIV_HI:CSC_BUSDIV_LO]}));
      s_d.sdiv = {s_d.bus_ratio, 1'b0};
      s_d.range_hi = s_q.ctrl2[CSC_RANGE_BIT];
      s_d.high_gain = s_q.ctrl2[CSC_GAIN_BIT];
      s_d.eosc = s_q.ctrl2[CSC_EOSC_BIT];
      s_d.loop_en = !i_stop && !(bypassed && s_q.ctrl2[CSC_LP_BIT] && !i_debug_mode);
      // internal reference: runs when used or enabled, in stop only if kept
      if (i_stop) begin
         s_d.irun = s_q.ctrl1[CSC_ISTOP_BIT] &&
                    (s_q.ctrl1[CSC_IOUT_BIT] || int_used);
         s_d.erun = s_q.ctrl2[CSC_ESTOP_BIT] &&
                    (s_q.ctrl2[CSC_EOUT_BIT] || ext_used);
      end else begin
         s_d.irun = s_q.ctrl1[CSC_IOUT_BIT] || s_q.ctrl1[CSC_IREF_BIT] ||
                    (s_d.src == CSC_SRC_INT);
         s_d.erun = s_q.ctrl2[CSC_EOUT_BIT] || !s_q.ctrl1[CSC_IREF_BIT] ||
                    (s_d.src == CSC_SRC_EXT);
      end
      s_d.igate = s_q.ctrl1[CSC_IOUT_BIT] && s_d.irun;
      s_d.egate = s_q.ctrl2[CSC_EOUT_BIT] && s_d.erun;
      s_d.osc_en = s_d.erun && s_q.ctrl2[CSC_EOSC_BIT];
      s_d.trim_o = s_q.trim;
      s_d.fine_o = s_q.fine;
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s_q <= '0;
         s_q.ctrl1 <= CSC_RST_CTRL1;
         s_q.ctrl2 <= CSC_RST_CTRL2;
         s_q.trim <= CSC_RST_TRIM;
         s_q.fine <= CSC_RST_FINE;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_bus_source_select = s_q.src;
   assign o_ref_div_ratio = s_q.ref_ratio;
   assign o_loop_ref_internal_select = s_q.iref;
   assign o_bus_div_ratio = s_q.bus_ratio;
   assign o_sys_div_ratio = s_q.sdiv;
   assign o_osc_range_high = s_q.range_hi;
   assign o_osc_high_gain = s_q.high_gain;
   assign o_osc_enable = s_q.osc_en;
   assign o_ext_ref_osc_request = s_q.eosc;
   assign o_loop_enable = s_q.loop_en;
   assign o_int_ref_run = s_q.irun;
   assign o_int_ref_clock_gate = s_q.igate;
   assign o_ext_ref_run = s_q.erun;
   assign o_ext_ref_clock_gate = s_q.egate;
   assign o_ref_trim = s_q.trim_o;
   assign o_fine_adjust_bit = s_q.fine_o;
endmodule

//--- sim/csc_regs_properties.sv
// checker: port-level properties of the clock source control registers
`timescale 1ns/1ps
module csc_regs_properties (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_stop,
   input wire logic i_debug_mode,
   input wire logic o_wb_ack,
   input wire logic [31:0] o_wb_dat,
   input wire logic [1:0] o_bus_source_select,
   input wire logic [7:0] o_ref_div_ratio,
   input wire logic [3:0] o_bus_div_ratio,
   input wire logic [4:0] o_sys_div_ratio,
   input wire logic o_loop_enable,
   input wire logic o_int_ref_run,
   input wire logic o_int_ref_clock_gate,
   input wire logic o_ext_ref_run,
   input wire logic o_ext_ref_clock_gate,
   input wire logic o_osc_enable,
   input wire logic o_ext_ref_osc_request,
   input wire csc_pkg::csc_mode_t o_mode
);
   import csc_pkg::*;
   logic [1:0] settle_q;
   logic settled;
   // derived outputs are only meaningful a few edges after reset
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         settle_q <= 2'h0;
      end else if (settle_q != 2'h3) begin
         settle_q <= settle_q + 2'h1;
      end
   end
   assign settled = (settle_q == 2'h3);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   sequence s_req; i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
   sequence s_ack; o_wb_ack ##1 !o_wb_ack; endsequence
   property p_ack; s_req |=> s_ack; endproperty
   property p_rdat; o_wb_ack |-> o_wb_dat[31:8] == 24'h0; endproperty
   property p_src; o_bus_source_select != 2'h3; endproperty
   property p_div;
      settled |-> $onehot(o_bus_div_ratio) && o_sys_div_ratio == {o_bus_div_ratio, 1'b0};
   endproperty
   property p_ref_ratio; settled |-> $onehot(o_ref_div_ratio); endproperty
   property p_igate; $rose(o_int_ref_clock_gate) |-> o_int_ref_run; endproperty
   property p_egate; $rose(o_ext_ref_clock_gate) |-> o_ext_ref_run; endproperty
   property p_osc; $rose(o_osc_enable) |-> o_ext_ref_osc_request; endproperty
   property p_stop; i_stop [*3] |-> !o_loop_enable; endproperty
   // loop enable is computed from the registered mode, so it lags o_mode by one cycle
   property p_lp;
      settled && !$past(i_stop) && o_mode inside {CSC_MODE_BYP_INT_LP, CSC_MODE_BYP_EXT_LP}
         && $past(o_mode) inside {CSC_MODE_BYP_INT, CSC_MODE_BYP_INT_LP, CSC_MODE_BYP_EXT,
         CSC_MODE_BYP_EXT_LP} |-> !o_loop_enable;
   endproperty
   property p_eng;
      settled && !i_stop && !$past(i_stop) && $stable(o_mode)
         && o_mode inside {CSC_MODE_ENG_INT, CSC_MODE_ENG_EXT} |=> o_loop_enable;
   endproperty
   property p_rst;
      @(posedge i_clk) disable iff (1'b0)
         i_srst |=> o_mode == CSC_MODE_ENG_INT && !o_wb_ack;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
   a_rdat: assert property (p_rdat) else $error("read data upper bits not zero");
   a_src: assert property (p_src) else $error("reserved source on output");
   a_div: assert property (p_div) else $error("bus divide ratio wrong");
   a_ref_ratio: assert property (p_ref_ratio) else $error("reference ratio not one-hot");
   a_igate: assert property (p_igate) else $error("internal gate without run");
   a_egate: assert property (p_egate) else $error("external gate without run");
   a_osc: assert property (p_osc) else $error("oscillator on without request");
   a_stop: assert property (p_stop) else $error("loop enabled in stop");
   a_lp: assert property (p_lp) else $error("loop on in low power bypass");
   a_eng: assert property (p_eng) else $error("loop off in engaged mode");
   a_rst: assert property (p_rst) else $error("reset did not restore mode");
endmodule
bind csc_regs csc_regs_properties u_props (
   .i_clk(i_clk), .i_srst(i_srst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
   .i_stop(i_stop), .i_debug_mode(i_debug_mode), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
   .o_bus_source_select(o_bus_source_select), .o_ref_div_ratio(o_ref_div_ratio),
   .o_bus_div_ratio(o_bus_div_ratio), .o_sys_div_ratio(o_sys_div_ratio),
   .o_loop_enable(o_loop_enable), .o_int_ref_run(o_int_ref_run),
   .o_int_ref_clock_gate(o_int_ref_clock_gate), .o_ext_ref_run(o_ext_ref_run),
   .o_ext_ref_clock_gate(o_ext_ref_clock_gate), .o_osc_enable(o_osc_enable),
   .o_ext_ref_osc_request(o_ext_ref_osc_request), .o_mode(o_mode)
);

//--- sim/csc_osc_model.sv
// partner: behavioural external oscillator steered by the control block
`timescale 1ns/1ps
module csc_osc_model (
   input wire logic i_osc_enable,
   input wire logic i_range_high,
   output logic o_osc_clk
);
   initial o_osc_clk = 1'b0;
   // runs only while requested, stands still low otherwise
   always begin
      if (i_osc_enable === 1'b1) begin
         #(i_range_high ? 20 : 80) o_osc_clk = ~o_osc_clk;
      end else begin
         o_osc_clk = 1'b0;
         @(i_osc_enable);
      end
   end
endmodule

//--- sim/csc_regs_tb_top.sv
// testbench: register bus and control output checks of the clock source control
`timescale 1ns/1ps
module csc_regs_tb_top;
   import csc_pkg::*;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, stop = 1'b0, dbg = 1'b0;
   logic [3:0] adr = 4'h0, sel = 4'hF;
   logic [31:0] wdat = 32'h0, rdat;
   logic ack, osc_en, rng, gain, osc_req, loop_en, irun, igate, erun, egate, fine, lref, osc_clk;
   logic [1:0] src;
   logic [7:0] ref_ratio, trim;
   logic [3:0] bus_ratio;
   logic [4:0] sdiv;
   csc_mode_t mode;
   int n_fail = 0, num_checks = 0, osc_edges = 0;
   logic [7:0] src_w [4] = '{8'h44, 8'h80, 8'h00, 8'hC4};
   logic [1:0] src_e [4] = '{2'h1, 2'h2, 2'h0, 2'h0};
   csc_mode_t mode_e [4] = '{CSC_MODE_BYP_INT, CSC_MODE_BYP_EXT, CSC_MODE_ENG_EXT,
      CSC_MODE_ENG_INT};
   always #2.5 i_clk = ~i_clk;
   always @(posedge osc_clk) osc_edges++;
   csc_regs dut (.i_clk(i_clk), .i_srst(i_srst), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .i_stop(stop),
      .i_debug_mode(dbg), .o_wb_ack(ack), .o_wb_dat(rdat), .o_bus_source_select(src),
      .o_ref_div_ratio(ref_ratio), .o_loop_ref_internal_select(lref),
      .o_bus_div_ratio(bus_ratio), .o_sys_div_ratio(sdiv), .o_osc_range_high(rng),
      .o_osc_high_gain(gain),
      .o_osc_enable(osc_en), .o_ext_ref_osc_request(osc_req), .o_loop_enable(loop_en),
      .o_int_ref_run(irun), .o_int_ref_clock_gate(igate), .o_ext_ref_run(erun),
      .o_ext_ref_clock_gate(egate), .o_ref_trim(trim), .o_fine_adjust_bit(fine),
      .o_mode(mode));
   csc_osc_model u_osc (.i_osc_enable(osc_en), .i_range_high(rng), .o_osc_clk(osc_clk));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      // request held until the rising edge at which ack is seen high
      do @(posedge i_clk); while (ack !== 1'b1);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rd(input string nm, input logic [3:0] a, input logic [7:0] e);
      logic [7:0] q;
      wb(1'b0, a, 8'h00, q);
      chk(nm, {24'h0, q}, {24'h0, e});
   endtask
   task automatic settle;
      repeat (4) @(negedge i_clk);
   endtask
   task automatic stop_test;
      if (n_fail == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge i_clk);
      i_srst <= 1'b0;
      rd("ctrl1", CSC_OFS_CTRL1, CSC_RST_CTRL1);
      rd("ctrl2", CSC_OFS_CTRL2, CSC_RST_CTRL2);
      rd("trim", CSC_OFS_TRIM, CSC_RST_TRIM);
      rd("stat", CSC_OFS_STAT, 8'h00);
      chk("dflt", {src, ref_ratio, bus_ratio, sdiv, loop_en, irun},
         {2'h0, 8'h01, 4'h2, 5'h04, 2'h3});
      wr(4'h2, 8'hFF);
      rd("unmapped", 4'h2, 8'h00);
      sel <= 4'hE;
      wr(CSC_OFS_TRIM, 8'h11);
      sel <= 4'hF;
      rd("sel0", CSC_OFS_TRIM, CSC_RST_TRIM);
      for (int b = 0; b < 4; b++) begin
         wr(CSC_OFS_CTRL2, {b[1:0], 6'h00});
         settle();
         chk("bus_div", {bus_ratio, sdiv}, {4'h1 << b, 5'h02 << b});
      end
      for (int r = 0; r < 8; r++) begin
         wr(CSC_OFS_CTRL1, {2'h0, r[2:0], 3'h4});
         settle();
         chk("ref_div", ref_ratio, 8'h01 << r);
      end
      // reference left undivided from here on, within the loop range
      for (int i = 0; i < 4; i++) begin
         wr(CSC_OFS_CTRL1, src_w[i]);
         settle();
         chk("src", src, src_e[i]);
         chk("mode", mode, mode_e[i]);
         chk("lref", lref, src_w[i][2]);
      end
      rd("rsvd", CSC_OFS_CTRL1, 8'h04);
      wr(CSC_OFS_CTRL1, 8'h44);
      wr(CSC_OFS_CTRL2, 8'h7E);
      repeat (30) @(negedge i_clk);
      chk("osc", {rng, gain, osc_req, osc_en, egate}, 5'h1F);
      chk("osc_clk", osc_edges > 0, 1'b1);
      chk("lp", {mode, loop_en}, {CSC_MODE_BYP_INT_LP, 1'b0});
      @(posedge i_clk);
      dbg <= 1'b1;
      settle();
      chk("dbg", {mode, loop_en}, {CSC_MODE_BYP_INT, 1'b1});
      @(posedge i_clk);
      dbg <= 1'b0;
      wr(CSC_OFS_CTRL2, 8'h43);
      wr(CSC_OFS_CTRL1, 8'h07);
      settle();
      chk("gates", {igate, egate}, 2'h3);
      @(posedge i_clk);
      stop <= 1'b1;
      settle();
      chk("stop_keep", {irun, erun, igate, egate, loop_en}, 5'h1E);
      wr(CSC_OFS_CTRL1, 8'h05);
      wr(CSC_OFS_CTRL2, 8'h40);
      settle();
      chk("stop_mode", {irun, erun, igate, egate}, 4'h8);
      wr(CSC_OFS_CTRL1, 8'h04);
      settle();
      chk("stop_off", irun, 1'b0);
      @(posedge i_clk);
      stop <= 1'b0;
      wr(CSC_OFS_TRIM, 8'hA5);
      wr(CSC_OFS_STAT, 8'hFF);
      settle();
      chk("trim", {trim, fine}, {8'hA5, 1'b1});
      rd("fine", CSC_OFS_STAT, 8'h01);
      @(posedge i_clk);
      i_srst <= 1'b1;
      @(posedge i_clk);
      i_srst <= 1'b0;
      rd("trim_rst", CSC_OFS_TRIM, CSC_RST_TRIM);
      chk("fine_rst", fine, CSC_RST_FINE);
      stop_test();
   end
   initial begin
      repeat (5000) @(posedge i_clk);
      n_fail++;
      stop_test();
   end
endmodule
